// >>> rtl/svm_top.sv
// Our own choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
module svm_top
  import svm_pkg::*;
#(
  parameter int SETTLE_CYC = SVM_SETTLE_CYC,
  parameter int IRQ_DELAY_CYC = SVM_IRQ_DELAY_CYC
) (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Analogue comparator side
  input  wire logic        cmp_below,
  output logic             detector_power,
  output logic             reference_power,
  output logic [11:0]      threshold_mv,
  // Core interface
  input  wire logic        core_powered_down,
  input  wire logic        irq_serviced,
  output logic             irq_group_flag,
  output logic             irq_vector_req,
  output logic             core_wake,
  // Interrupt
  output logic             irq
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [11:0] thr_mv(input logic [2:0] code);
    case (svm_thr_t'(code))
      SVM_T2V0: thr_mv = SVM_MV_2V0;
      SVM_T2V2: thr_mv = SVM_MV_2V2;
      SVM_T2V4: thr_mv = SVM_MV_2V4;
      SVM_T2V7: thr_mv = SVM_MV_2V7;
      SVM_T3V0: thr_mv = SVM_MV_3V0;
      SVM_T3V3: thr_mv = SVM_MV_3V3;
      SVM_T3V6: thr_mv = SVM_MV_3V6;
      SVM_T4V0: thr_mv = SVM_MV_4V0;
      default:  thr_mv = SVM_MV_2V0;
    endcase
  endfunction

  function automatic logic is_off(input logic [7:0] a, input logic [7:0] off);
    is_off = (a[7:2] == off[7:2]);
  endfunction

  initial
  begin
    if (SETTLE_CYC < 1 || IRQ_DELAY_CYC < 1)
      $error("svm_top: delay counts must be at least 1");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic       detector_on_reg;
  logic [2:0] threshold_select_reg;
  logic       low_supply_flag_reg;
  logic       supply_warn_irq_flag_reg;
  logic       supply_warn_irq_en_reg;
  logic       irq_group_en_reg;
  logic       global_irq_en_reg;
  logic       stack_full_reg;
  logic       irq_group_flag_reg;
  logic [3:0] ev_status_reg;
  logic [3:0] ev_mask_reg;
  logic       req_prev_reg;
  logic       ready_prev_reg;
  logic [2:0] cmp_sync_reg;
  logic       settled;
  logic       irq_due;
  logic       irq_due_prev_reg;

  // Write channel state
  logic       aw_held_reg;
  logic [7:0] aw_addr_reg;
  logic       w_held_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic       wr_go;
  logic [3:0] ev_set;

  // ----------------------------------------------------------------
  // Comparator input, three stages
  // ----------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      cmp_sync_reg <= 3'h0;
    else
      cmp_sync_reg <= {cmp_sync_reg[1:0], cmp_below};
  end

  // No hysteresis on purpose: chatter near threshold reaches software
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !detector_on_reg)
      low_supply_flag_reg <= 1'b0;
    else if (cmp_sync_reg[2] == cmp_sync_reg[1])
      low_supply_flag_reg <= cmp_sync_reg[2];
  end

  // ----------------------------------------------------------------
  // Settling and interrupt delays
  // ----------------------------------------------------------------
  svm_delay #(.CYCLES(SETTLE_CYC)) u_settle (
    .aclk    (aclk),
    .aresetn (aresetn),
    .level   (detector_on_reg),
    .done    (settled)
  );

  svm_delay #(.CYCLES(IRQ_DELAY_CYC)) u_irq_delay (
    .aclk    (aclk),
    .aresetn (aresetn),
    .level   (low_supply_flag_reg),
    .done    (irq_due)
  );

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      irq_due_prev_reg <= 1'b0;
      ready_prev_reg   <= 1'b0;
    end
    else
    begin
      irq_due_prev_reg <= irq_due;
      ready_prev_reg   <= settled;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite write path
  // ----------------------------------------------------------------
  assign wr_go = aw_held_reg && w_held_reg && !s_axi_bvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_held_reg <= 1'b1;
      aw_addr_reg <= s_axi_awaddr;
    end
    else if (wr_go)
      aw_held_reg <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_held_reg <= 1'b0;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_held_reg <= 1'b1;
      w_data_reg <= s_axi_wdata;
      w_strb_reg <= s_axi_wstrb;
    end
    else if (wr_go)
      w_held_reg <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
    end
    else
    begin
      s_axi_awready <= !aw_held_reg && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready  <= !w_held_reg && !(s_axi_wvalid && s_axi_wready);
      if (wr_go)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (is_off(aw_addr_reg, SVM_CTRL_OFF) || is_off(aw_addr_reg, SVM_IRQ_OFF) ||
                         is_off(aw_addr_reg, SVM_STAT_OFF) || is_off(aw_addr_reg, SVM_MASK_OFF))
                        ? 2'h0 : 2'h2;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      detector_on_reg      <= SVM_CTRL_RST[SVM_ON_BIT];
      threshold_select_reg <= SVM_CTRL_RST[SVM_THR_MSB:0];
    end
    else if (wr_go && is_off(aw_addr_reg, SVM_CTRL_OFF) && w_strb_reg[0])
    begin
      detector_on_reg      <= w_data_reg[SVM_ON_BIT];
      threshold_select_reg <= w_data_reg[SVM_THR_MSB:0];
    end
  end

  // ----------------------------------------------------------------
  // Interrupt group control; set beats software clear
  // ----------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      supply_warn_irq_en_reg <= 1'b0;
      irq_group_en_reg       <= 1'b0;
      global_irq_en_reg      <= 1'b0;
      stack_full_reg         <= 1'b0;
    end
    else
    begin
      if (wr_go && is_off(aw_addr_reg, SVM_IRQ_OFF) && w_strb_reg[0])
      begin
        supply_warn_irq_en_reg <= w_data_reg[SVM_IRQE_BIT];
        irq_group_en_reg       <= w_data_reg[SVM_GRPE_BIT];
        global_irq_en_reg      <= w_data_reg[SVM_GIE_BIT];
        stack_full_reg         <= w_data_reg[SVM_STACKF_BIT];
      end
      else if (irq_serviced)
        global_irq_en_reg <= 1'b0;
    end
  end

  // Active in power-down too: nothing here looks at core_powered_down
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      supply_warn_irq_flag_reg <= 1'b0;
    else if (irq_due && !irq_due_prev_reg)
      supply_warn_irq_flag_reg <= 1'b1;
    else if (wr_go && is_off(aw_addr_reg, SVM_IRQ_OFF) && w_strb_reg[0])
      supply_warn_irq_flag_reg <= w_data_reg[SVM_IRQF_BIT];
  end

  // Group flag is set on the rise of the source flag; servicing clears the group flag and the global enable, not the source flag
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq_group_flag_reg <= 1'b0;
    else if (supply_warn_irq_flag_reg && !req_prev_reg)
      irq_group_flag_reg <= 1'b1;
    else if (irq_serviced)
      irq_group_flag_reg <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      req_prev_reg <= 1'b0;
    else
      req_prev_reg <= supply_warn_irq_flag_reg;
  end

  // ----------------------------------------------------------------
  // Event status and mask
  // ----------------------------------------------------------------
  always_comb
  begin
    ev_set = 4'h0;
    ev_set[SVM_EV_IRQ]   = supply_warn_irq_flag_reg && !req_prev_reg;
    ev_set[SVM_EV_WAKE]  = supply_warn_irq_flag_reg && !req_prev_reg && core_powered_down;
    ev_set[SVM_EV_VEC]   = irq_vector_req && irq_serviced;
    ev_set[SVM_EV_READY] = settled && !ready_prev_reg;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ev_status_reg <= SVM_EV_RST;
      ev_mask_reg   <= SVM_EV_RST;
    end
    else
    begin
      if (wr_go && is_off(aw_addr_reg, SVM_STAT_OFF) && w_strb_reg[0])
        ev_status_reg <= (ev_status_reg & ~w_data_reg[3:0]) | ev_set;
      else
        ev_status_reg <= ev_status_reg | ev_set;
      if (wr_go && is_off(aw_addr_reg, SVM_MASK_OFF) && w_strb_reg[0])
        ev_mask_reg <= w_data_reg[3:0];
    end
  end

  // ----------------------------------------------------------------
  // Outputs to analogue and core
  // ----------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      detector_power  <= 1'b0;
      reference_power <= 1'b0;
      threshold_mv    <= SVM_MV_2V0;
      irq_group_flag  <= 1'b0;
      irq_vector_req  <= 1'b0;
      core_wake       <= 1'b0;
      irq             <= 1'b0;
    end
    else
    begin
      detector_power  <= detector_on_reg;
      reference_power <= detector_on_reg;
      threshold_mv    <= thr_mv(threshold_select_reg);
      irq_group_flag  <= irq_group_flag_reg;
      irq_vector_req  <= global_irq_en_reg && supply_warn_irq_en_reg && irq_group_en_reg
                         && !stack_full_reg && irq_group_flag_reg;
      core_wake       <= core_powered_down && supply_warn_irq_flag_reg && !req_prev_reg;
      irq             <= |(ev_status_reg & ev_mask_reg);
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read path
  // ----------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'h0;
    end
    else
    begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= 2'h0;
        s_axi_rdata  <= 32'h0000_0000;
        if (is_off(s_axi_araddr, SVM_CTRL_OFF))
          // Flag is reported live; software honours the settle delay
          s_axi_rdata <= {26'h0, low_supply_flag_reg, detector_on_reg, 1'b0, threshold_select_reg};
        else if (is_off(s_axi_araddr, SVM_IRQ_OFF))
          s_axi_rdata <= {27'h0, stack_full_reg, global_irq_en_reg, irq_group_en_reg,
                          supply_warn_irq_en_reg, supply_warn_irq_flag_reg};
        else if (is_off(s_axi_araddr, SVM_STAT_OFF))
          s_axi_rdata <= {28'h0, ev_status_reg};
        else if (is_off(s_axi_araddr, SVM_MASK_OFF))
          s_axi_rdata <= {28'h0, ev_mask_reg};
        else
          s_axi_rresp <= 2'h2;
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// >>> rtl/svm_pkg.sv
package svm_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] SVM_CTRL_OFF    = 8'h00;
  localparam logic [7:0] SVM_IRQ_OFF     = 8'h04;
  localparam logic [7:0] SVM_STAT_OFF    = 8'h08;
  localparam logic [7:0] SVM_MASK_OFF    = 8'h0c;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int SVM_FLAG_BIT    = 5;
  localparam int SVM_ON_BIT      = 4;
  localparam int SVM_THR_MSB     = 2;
  localparam int SVM_IRQF_BIT    = 0;
  localparam int SVM_IRQE_BIT    = 1;
  localparam int SVM_GRPE_BIT    = 2;
  localparam int SVM_GIE_BIT     = 3;
  localparam int SVM_STACKF_BIT  = 4;
  localparam int SVM_EV_IRQ      = 0;
  localparam int SVM_EV_WAKE     = 1;
  localparam int SVM_EV_VEC      = 2;
  localparam int SVM_EV_READY    = 3;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] SVM_CTRL_RST    = 8'h00;
  localparam logic [3:0] SVM_EV_RST      = 4'h0;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int SVM_CLK_HZ          = 25000000;
  localparam int SVM_SETTLE_US       = 15;
  localparam int SVM_IRQ_DELAY_US    = 45;
  localparam int SVM_SETTLE_CYC      = (SVM_SETTLE_US * (SVM_CLK_HZ / 1000000));
  localparam int SVM_IRQ_DELAY_CYC   = (SVM_IRQ_DELAY_US * (SVM_CLK_HZ / 1000000));

  // ----------------------------------------------------------------
  // Threshold codes, millivolts
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SVM_T2V0, SVM_T2V2, SVM_T2V4, SVM_T2V7, SVM_T3V0, SVM_T3V3, SVM_T3V6, SVM_T4V0
  } svm_thr_t;

  localparam logic [11:0] SVM_MV_2V0 = 12'h7d0;
  localparam logic [11:0] SVM_MV_2V2 = 12'h898;
  localparam logic [11:0] SVM_MV_2V4 = 12'h960;
  localparam logic [11:0] SVM_MV_2V7 = 12'ha8c;
  localparam logic [11:0] SVM_MV_3V0 = 12'hbb8;
  localparam logic [11:0] SVM_MV_3V3 = 12'hce4;
  localparam logic [11:0] SVM_MV_3V6 = 12'he10;
  localparam logic [11:0] SVM_MV_4V0 = 12'hfa0;

endpackage

// >>> rtl/svm_delay.sv
`timescale 1ns/1ps
// Counts a level that must stay high for CYCLES clocks; done stays high while it does.
module svm_delay #(
  parameter int CYCLES = 1
) (
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // Level in and qualified level out
  input  wire logic level,
  output logic      done
);

  localparam int W = $clog2(CYCLES + 1);

  logic [W-1:0] cnt_reg;

  initial
  begin
    if (CYCLES < 1)
      $error("svm_delay: CYCLES must be at least 1");
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn || !level)
      cnt_reg <= '0;
    else if (cnt_reg != W'(CYCLES))
      cnt_reg <= cnt_reg + W'(1);
  end

  assign done = level && (cnt_reg == W'(CYCLES));

endmodule

// >>> testbench/svm_top_sva.sv
`timescale 1ns/1ps
module svm_top_sva #(
  parameter int SETTLE_CYC    = 4,
  parameter int IRQ_DELAY_CYC = 6
) (
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Register bus
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  // Monitor and core side
  input wire logic        detector_power,
  input wire logic        reference_power,
  input wire logic [11:0] threshold_mv,
  input wire logic        core_powered_down,
  input wire logic        irq_serviced,
  input wire logic        irq_group_flag,
  input wire logic        irq_vector_req,
  input wire logic        core_wake
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_power_pair: assert property (detector_power == reference_power)
    else $error("reference power differs from detector power");
  a_thr_decode: assert property (threshold_mv inside {12'h7d0, 12'h898, 12'h960, 12'ha8c,
    12'hbb8, 12'hce4, 12'he10, 12'hfa0})
    else $error("threshold outside the decoded set");
  a_wake_pulse: assert property (core_wake |=> !core_wake)
    else $error("wake longer than one cycle");
  a_wake_down: assert property (core_wake |-> core_powered_down || $past(core_powered_down))
    else $error("wake while core running");
  a_vector_group: assert property (irq_vector_req |-> irq_group_flag || $past(irq_group_flag))
    else $error("vector without group flag");
  a_service_stops: assert property (irq_serviced |=> ##1 !irq_vector_req)
    else $error("vector stays after service");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_read_ends: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer repeated");
  a_write_ends: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer repeated");
  a_resp_legal: assert property (s_axi_bvalid |-> s_axi_bresp inside {2'h0, 2'h2})
    else $error("illegal write response");
  a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("read data above byte not zero");

  c_wake: cover property (core_wake);
  c_vector: cover property (irq_vector_req);
  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule

bind svm_top svm_top_sva #(.SETTLE_CYC(SETTLE_CYC), .IRQ_DELAY_CYC(IRQ_DELAY_CYC)) chk_u (
  .aclk(aclk), .aresetn(aresetn), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .detector_power(detector_power), .reference_power(reference_power), .threshold_mv(threshold_mv),
  .core_powered_down(core_powered_down), .irq_serviced(irq_serviced), .irq_group_flag(irq_group_flag),
  .irq_vector_req(irq_vector_req), .core_wake(core_wake));

// >>> testbench/test_supply_voltage_monitor.sv
`timescale 1ns/1ps
module test_supply_voltage_monitor;
  import svm_pkg::*;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        cmp = 1'b0, pdown = 1'b0, serviced = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        awready, wready, bvalid, arready, rvalid, det_pwr, ref_pwr, grp, vec, wake, irq;
  logic [1:0]  bresp, rresp, r;
  logic [31:0] rdata, d;
  logic [11:0] thr_mv;
  logic [11:0] mv_tab [8] = '{12'h7d0, 12'h898, 12'h960, 12'ha8c, 12'hbb8, 12'hce4, 12'he10, 12'hfa0};
  int          n_fail = 0;
  int          total_checks = 0;

  always #20 aclk = ~aclk;

  svm_top #(.SETTLE_CYC(4), .IRQ_DELAY_CYC(6)) dut_u (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .cmp_below(cmp), .detector_power(det_pwr),
    .reference_power(ref_pwr), .threshold_mv(thr_mv), .core_powered_down(pdown), .irq_serviced(serviced),
    .irq_group_flag(grp), .irq_vector_req(vec), .core_wake(wake), .irq(irq));

  // ----------------------------------------------------------------
  // Reporting
  // ----------------------------------------------------------------
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // A bound that runs out is a mismatch and ends the run at once
  task automatic tmo(input int n);
    if (n >= 40)
    begin
      chk(32'(n), 32'h0);
      finish_test();
    end
  endtask

  // ----------------------------------------------------------------
  // Bus master
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
    end
    while (!bvalid && n < 40);
    bready <= 1'b0;
    r = bresp;
    tmo(n);
  endtask

  task automatic rd(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (arready)
        arvalid <= 1'b0;
    end
    while (!rvalid && n < 40);
    rready <= 1'b0;
    d = rdata;
    r = rresp;
    tmo(n);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rd(SVM_CTRL_OFF);
    chk(d, 32'h0);
    chk(r, 32'h0);
    chk(32'(det_pwr), 32'h0);
    chk(32'(thr_mv), 32'h7d0);
    rd(SVM_IRQ_OFF);
    chk(d, 32'h0);
    $display("reset test done");
  endtask

  task automatic t_thresholds();
    for (int i = 0; i < 8; i++)
    begin
      wr(SVM_CTRL_OFF, 32'h10 | i);
      repeat (2) @(posedge aclk);
      chk(32'(thr_mv), 32'(mv_tab[i]));
      chk(32'({det_pwr, ref_pwr}), 32'h3);
      rd(SVM_CTRL_OFF);
      chk(d, 32'h10 | i);
    end
    wr(SVM_CTRL_OFF, 32'hff);
    rd(SVM_CTRL_OFF);
    chk(d, 32'h17);
    wr(SVM_CTRL_OFF, 32'h00);
    repeat (2) @(posedge aclk);
    chk(32'({det_pwr, ref_pwr}), 32'h0);
    $display("threshold test done");
  endtask

  task automatic t_flag();
    // Settle-done event is cleared first so that its rise after enabling is what gets seen
    wr(SVM_STAT_OFF, 32'h0f);
    wr(SVM_CTRL_OFF, 32'h13);
    repeat (6) @(posedge aclk);
    rd(SVM_STAT_OFF);
    chk(32'(d[SVM_EV_READY]), 32'h1);
    @(posedge aclk);
    cmp <= 1'b1;
    repeat (8) @(posedge aclk);
    rd(SVM_CTRL_OFF);
    chk(d, 32'h33);
    cmp <= 1'b0;
    repeat (8) @(posedge aclk);
    rd(SVM_CTRL_OFF);
    chk(d, 32'h13);
    cmp <= 1'b1;
    wr(SVM_CTRL_OFF, 32'h03);
    repeat (8) @(posedge aclk);
    rd(SVM_CTRL_OFF);
    chk(d, 32'h03);
    cmp <= 1'b0;
    $display("flag test done");
  endtask

  task automatic t_irq();
    wr(SVM_IRQ_OFF, 32'h0e);
    wr(SVM_MASK_OFF, 32'h00);
    wr(SVM_CTRL_OFF, 32'h10);
    repeat (8) @(posedge aclk);
    cmp <= 1'b1;
    rd(SVM_IRQ_OFF);
    chk(d, 32'h0e);
    repeat (20) @(posedge aclk);
    rd(SVM_IRQ_OFF);
    chk(d, 32'h0f);
    chk(32'({grp, vec, irq}), 32'h6);
    wr(SVM_MASK_OFF, 32'h01);
    repeat (2) @(posedge aclk);
    chk(32'(irq), 32'h1);
    wr(SVM_IRQ_OFF, 32'h1f);
    repeat (3) @(posedge aclk);
    chk(32'(vec), 32'h0);
    wr(SVM_IRQ_OFF, 32'h0f);
    repeat (3) @(posedge aclk);
    chk(32'(vec), 32'h1);
    serviced <= 1'b1;
    @(posedge aclk);
    serviced <= 1'b0;
    // Group flag output is registered: it drops one edge after the service pulse is taken
    repeat (2) @(posedge aclk);
    chk(32'(grp), 32'h0);
    rd(SVM_IRQ_OFF);
    chk(d, 32'h07);
    rd(SVM_STAT_OFF);
    chk(d, 32'h0d);
    wr(SVM_STAT_OFF, 32'h0f);
    repeat (2) @(posedge aclk);
    chk(32'(irq), 32'h0);
    cmp <= 1'b0;
    wr(SVM_IRQ_OFF, 32'h00);
    $display("interrupt test done");
  endtask

  task automatic t_wake();
    int   n;
    logic seen;
    pdown <= 1'b1;
    repeat (8) @(posedge aclk);
    cmp <= 1'b1;
    n = 0;
    while (wake !== 1'b1 && n < 40)
    begin
      @(posedge aclk);
      n++;
    end
    chk(32'(n < 40), 32'h1);
    cmp <= 1'b0;
    pdown <= 1'b0;
    wr(SVM_IRQ_OFF, 32'h00);
    // Presetting the request flag before power-down hides the next drop
    wr(SVM_IRQ_OFF, 32'h01);
    pdown <= 1'b1;
    @(posedge aclk);
    cmp <= 1'b1;
    seen = 1'b0;
    repeat (40)
    begin
      @(posedge aclk);
      seen = seen | wake;
    end
    chk(32'(seen), 32'h0);
    cmp <= 1'b0;
    pdown <= 1'b0;
    wr(SVM_IRQ_OFF, 32'h00);
    $display("wake test done");
  endtask

  task automatic t_unmapped();
    rd(8'h10);
    chk({r, d[29:0]}, 32'h80000000);
    wr(8'h10, 32'hff);
    chk(r, 32'h2);
    $display("unmapped test done");
  endtask

  initial
  begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_reset();
    t_thresholds();
    t_flag();
    t_irq();
    t_wake();
    t_unmapped();
    finish_test();
  end
endmodule
